// ===== design/awce_engine.sv
`timescale 1ns/1ps
`include "awce_regs.svh"
module awce_engine #(
   parameter int MAX_BLOCK = 1               // largest block size accepted
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire awce_pkg::awce_apb_t   apbReq,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic                       irq,
   output logic                       dmarq,
   input  wire logic                  dmaStb,
   input  wire logic [15:0]           dmaData,
   input  wire awce_pkg::awce_info_t  sectInfo,
   output awce_pkg::awce_media_t      mediaOut,
   input  wire logic                  mediaDone,
   input  wire logic                  mediaErr,
   input  wire logic [7:0]            mediaRdAddr,
   output logic [15:0]                mediaRdData
);
   // busy deadline, rounded down to whole cycles, at least one
   localparam int BSY_CYC_RAW = `AWCE_BSY_MAX_NS / `AWCE_CLK_NS;
   localparam int BSY_CYC     = (BSY_CYC_RAW < 1) ? 1 : BSY_CYC_RAW;

   // refuse block sizes the counters cannot hold
   if (MAX_BLOCK < 1 || MAX_BLOCK > 255) begin : g_chk
      $error("MAX_BLOCK out of range");
   end

   // complete block state
   typedef struct packed {
      awce_pkg::awce_state_t state;
      logic [7:0]            cmd;       // command in progress
      logic [7:0]            secCnt;    // task-file count
      logic [7:0]            secNum;
      logic [7:0]            cylLo;
      logic [7:0]            cylHi;
      logic [7:0]            devHead;
      logic [7:0]            err;       // error register
      logic                  errFlag;
      logic                  bsy;
      logic                  drq;
      logic                  irq;
      logic                  dmarq;
      logic                  blkEn;     // block mode enabled
      logic [7:0]            blkSize;
      logic [7:0]            blkLeft;   // sectors left in block
      logic [8:0]            remain;    // sectors left in command
      logic [7:0]            wordCnt;
      logic [1:0]            eccCnt;
      awce_pkg::awce_info_t  info;      // captured sector facts
      logic [31:0]           prdata;
      logic                  pready;
      logic                  pslverr;
      awce_pkg::awce_media_t media;
   } awce_regs_t;

   awce_regs_t q;                 // registered state
   awce_regs_t d;                 // next state
   logic [15:0] secBuf [256];     // sector buffer
   logic        bufWe;            // buffer write strobe
   logic [15:0] bufData;          // buffer write data
   logic        setup;            // apb setup phase
   logic        acc;              // apb access completes
   logic        isLong;
   logic        isMulti;
   logic        isDma;
   logic [27:0] lbaNow;

   // one byte of the information block, zero where reserved
   function automatic logic [7:0] infoByte(input logic [8:0] idx,
                                           input awce_pkg::awce_info_t f);
      case (idx)
         `AWCE_TB_CYLMSB: infoByte = f.cyl[15:8];
         `AWCE_TB_CYLLSB: infoByte = f.cyl[7:0];
         `AWCE_TB_HEAD:   infoByte = f.head;
         `AWCE_TB_SECT:   infoByte = f.sect;
         `AWCE_TB_LBA0:   infoByte = f.lba[23:16];
         `AWCE_TB_LBA1:   infoByte = f.lba[15:8];
         `AWCE_TB_LBA2:   infoByte = f.lba[7:0];
         `AWCE_TB_ERASED: infoByte = f.erased ? 8'hff : 8'h00;
         `AWCE_TB_HOT0:   infoByte = f.hot[23:16];
         `AWCE_TB_HOT1:   infoByte = f.hot[15:8];
         `AWCE_TB_HOT2:   infoByte = f.hot[7:0];
         default:         infoByte = 8'h00;
      endcase
   endfunction : infoByte

   // command decode helpers
   assign isLong  = (q.cmd == `AWCE_OP_LONG0) || (q.cmd == `AWCE_OP_LONG1);
   assign isMulti = (q.cmd == `AWCE_OP_MULTI) ||
                    (q.cmd == `AWCE_OP_MULTINE);
   assign isDma   = (q.cmd == `AWCE_OP_WRDMA);
   assign lbaNow  = {q.devHead[3:0], q.cylHi, q.cylLo, q.secNum};
   assign setup   = apbReq.psel && !apbReq.penable;
   assign acc     = apbReq.psel && apbReq.penable && q.pready;

   // next-state logic
   always_comb begin
      logic        word;
      logic [27:0] lbaNxt;
      logic [8:0]  cntFull;
      word    = 1'b0;
      lbaNxt  = lbaNow + 28'h1;
      cntFull = (q.secCnt == 8'h00) ? `AWCE_FULL_COUNT : {1'b0, q.secCnt};
      d       = q;
      bufWe   = 1'b0;
      bufData = 16'h0000;
      d.media.req = 1'b0;
      // apb answer one cycle after setup
      d.pready = setup;
      if (setup) begin
         d.pslverr = 1'b0;
         case (apbReq.paddr)
            `AWCE_OFF_DATA:    d.prdata = {16'h0000,
               infoByte({q.wordCnt, 1'b1}, q.info),
               infoByte({q.wordCnt, 1'b0}, q.info)};
            `AWCE_OFF_SECCNT:  d.prdata = {24'h0, q.secCnt};
            `AWCE_OFF_SECNUM:  d.prdata = {24'h0, q.secNum};
            `AWCE_OFF_CYLLO:   d.prdata = {24'h0, q.cylLo};
            `AWCE_OFF_CYLHI:   d.prdata = {24'h0, q.cylHi};
            `AWCE_OFF_DEVHEAD: d.prdata = {24'h0, q.devHead};
            `AWCE_OFF_CMDSTAT: d.prdata = {24'h0, q.bsy, !q.bsy, 1'b0,
               1'b1, q.drq, 2'b00, q.errFlag};
            `AWCE_OFF_ERROR:   d.prdata = {24'h0, q.err};
            `AWCE_OFF_MULTI:   d.prdata = {16'h0, 8'(MAX_BLOCK),
               q.blkEn ? q.blkSize : 8'h00};
            default: begin
               d.prdata  = 32'h0;
               d.pslverr = 1'b1;
            end
         endcase
      end
      // task-file writes while idle
      if (acc && apbReq.pwrite && !q.bsy && !q.drq) begin
         case (apbReq.paddr)
            `AWCE_OFF_SECCNT:  d.secCnt  = apbReq.pwdata[7:0];
            `AWCE_OFF_SECNUM:  d.secNum  = apbReq.pwdata[7:0];
            `AWCE_OFF_CYLLO:   d.cylLo   = apbReq.pwdata[7:0];
            `AWCE_OFF_CYLHI:   d.cylHi   = apbReq.pwdata[7:0];
            `AWCE_OFF_DEVHEAD: d.devHead = apbReq.pwdata[7:0];
            `AWCE_OFF_CMDSTAT: begin
               d.cmd     = apbReq.pwdata[7:0];
               d.state   = awce_pkg::ST_START;
               d.bsy     = 1'b1;
               d.irq     = 1'b0;
               d.err     = 8'h00;
               d.errFlag = 1'b0;
               d.info    = sectInfo;
            end
            default: ;
         endcase
      end
      // status read acknowledges the interrupt
      if (acc && !apbReq.pwrite && apbReq.paddr == `AWCE_OFF_CMDSTAT)
         d.irq = 1'b0;
      // pick the data word source; pio is ignored during dma
      if (q.state == awce_pkg::ST_XFER) begin
         if (isDma) begin
            word    = dmaStb && q.dmarq;
            bufData = dmaData;
         end else begin
            word    = acc && apbReq.pwrite &&
                      apbReq.paddr == `AWCE_OFF_DATA;
            bufData = apbReq.pwdata[15:0];
         end
      end
      // command sequencer
      case (q.state)
         awce_pkg::ST_IDLE: ;
         awce_pkg::ST_START: begin
            d.wordCnt = 8'h00;
            d.eccCnt  = 2'b00;
            d.bsy     = 1'b0;
            d.state   = awce_pkg::ST_XFER;
            d.drq     = 1'b1;
            case (q.cmd)
               `AWCE_OP_XLATE: begin
                  d.state = awce_pkg::ST_OUT;
                  d.irq   = 1'b1;
               end
               `AWCE_OP_WRBUF, `AWCE_OP_LONG0, `AWCE_OP_LONG1:
                  d.remain = 9'h001;
               `AWCE_OP_WRDMA: begin
                  d.remain = cntFull;
                  d.dmarq  = 1'b1;
               end
               `AWCE_OP_MULTI, `AWCE_OP_MULTINE: begin
                  d.remain = cntFull;
                  if (!q.blkEn) begin
                     d.state   = awce_pkg::ST_IDLE;
                     d.drq     = 1'b0;
                     d.err     = `AWCE_ER_ABRT;
                     d.errFlag = 1'b1;
                     d.irq     = 1'b1;
                  end else begin
                     d.blkLeft = ({1'b0, q.blkSize} < cntFull) ?
                                 q.blkSize : cntFull[7:0];
                     d.irq     = 1'b1;
                  end
               end
               `AWCE_OP_SETMULT: begin
                  d.state = awce_pkg::ST_IDLE;
                  d.drq   = 1'b0;
                  d.irq   = 1'b1;
                  d.blkEn = (q.secCnt != 8'h00) &&
                            (q.secCnt <= 8'(MAX_BLOCK));
                  d.blkSize = q.secCnt;
                  if (q.secCnt > 8'(MAX_BLOCK)) begin
                     d.err     = `AWCE_ER_ABRT;
                     d.errFlag = 1'b1;
                  end
               end
               default: begin
                  d.state   = awce_pkg::ST_IDLE;
                  d.drq     = 1'b0;
                  d.err     = `AWCE_ER_ABRT;
                  d.errFlag = 1'b1;
                  d.irq     = 1'b1;
               end
            endcase
         end
         awce_pkg::ST_XFER: begin
            if (word) begin
               bufWe     = 1'b1;
               d.wordCnt = q.wordCnt + 8'h01;
               if (q.wordCnt == `AWCE_LAST_WORD) begin
                  if (isLong) begin
                     d.state = awce_pkg::ST_ECC;
                  end else begin
                     d.drq   = 1'b0;
                     d.dmarq = 1'b0;
                     d.bsy   = 1'b1;
                     d.state = awce_pkg::ST_PROG;
                     d.media.req = (q.cmd != `AWCE_OP_WRBUF);
                     d.media.lba = lbaNow;
                  end
               end
            end
         end
         awce_pkg::ST_ECC: begin
            // check bytes are counted and dropped
            if (acc && apbReq.pwrite && apbReq.paddr == `AWCE_OFF_DATA) begin
               d.eccCnt = q.eccCnt + 2'b01;
               if (q.eccCnt == `AWCE_LAST_ECC) begin
                  d.drq       = 1'b0;
                  d.bsy       = 1'b1;
                  d.state     = awce_pkg::ST_PROG;
                  d.media.req = 1'b1;
                  d.media.lba = lbaNow;
               end
            end
         end
         awce_pkg::ST_PROG: begin
            if (q.cmd == `AWCE_OP_WRBUF) begin
               d.bsy   = 1'b0;
               d.irq   = 1'b1;
               d.state = awce_pkg::ST_IDLE;
            end else if (mediaDone) begin
               if (mediaErr) begin
                  d.err     = `AWCE_ER_IDNF;
                  d.errFlag = 1'b1;
                  d.bsy     = 1'b0;
                  d.irq     = 1'b1;
                  d.state   = awce_pkg::ST_IDLE;
               end else begin
                  d.remain  = q.remain - 9'h001;
                  d.secCnt  = q.secCnt - 8'h01;
                  {d.devHead[3:0], d.cylHi, d.cylLo, d.secNum} = lbaNxt;
                  d.bsy     = 1'b0;
                  d.wordCnt = 8'h00;
                  if (q.remain == 9'h001) begin
                     d.irq   = 1'b1;
                     d.state = awce_pkg::ST_IDLE;
                  end else begin
                     d.drq   = 1'b1;
                     d.state = awce_pkg::ST_XFER;
                     d.dmarq = isDma;
                     if (isMulti) begin
                        d.blkLeft = q.blkLeft - 8'h01;
                        if (q.blkLeft == 8'h01) begin
                           d.irq     = 1'b1;
                           d.blkLeft = ({1'b0, q.blkSize} < d.remain) ?
                                       q.blkSize : d.remain[7:0];
                        end
                     end else if (!isDma) begin
                        d.irq = 1'b1;
                     end
                  end
               end
            end
         end
         awce_pkg::ST_OUT: begin
            // information block read out word by word
            if (acc && !apbReq.pwrite && apbReq.paddr == `AWCE_OFF_DATA) begin
               d.wordCnt = q.wordCnt + 8'h01;
               if (q.wordCnt == `AWCE_LAST_WORD) begin
                  d.drq   = 1'b0;
                  d.state = awce_pkg::ST_IDLE;
               end
            end
         end
         default: d.state = awce_pkg::ST_IDLE;
      endcase
   end

   // state register, frozen while ce is low
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   // sector buffer: host fills, media manager reads
   always_ff @(posedge sys_clk) begin
      if (ce) begin
         if (bufWe)
            secBuf[q.wordCnt] <= bufData;
         mediaRdData <= secBuf[mediaRdAddr];
      end
   end

   // outputs straight from the state register
   assign prdata   = q.prdata;
   assign pready   = q.pready;
   assign pslverr  = q.pslverr;
   assign irq      = q.irq;
   assign dmarq    = q.dmarq;
   assign mediaOut = q.media;

   // checks
   logic cmdAcc;
   assign cmdAcc = acc && apbReq.pwrite &&
                   apbReq.paddr == `AWCE_OFF_CMDSTAT && !q.bsy && !q.drq;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst || !ce);

   a_bsy_after_cmd: assert property (
      cmdAcc |-> ##[1:BSY_CYC] q.bsy)
      else $error("busy not raised after command");
   a_dma_qualified: assert property (
      q.dmarq |-> isDma && q.drq && q.state == awce_pkg::ST_XFER)
      else $error("dma request outside dma data phase");
   a_dma_one_irq: assert property (
      $rose(q.irq) && isDma |-> q.state == awce_pkg::ST_IDLE)
      else $error("dma interrupt before the end");
   a_dma_bsy_drq: assert property (
      isDma && q.state != awce_pkg::ST_IDLE |-> q.bsy || q.drq)
      else $error("dma write shows neither busy nor drq");
   a_no_first_irq: assert property (
      q.state == awce_pkg::ST_START && (isDma || isLong ||
      q.cmd == `AWCE_OP_WRBUF) |=> !q.irq && q.drq)
      else $error("interrupt before first data");
   a_last_busy: assert property (
      q.state == awce_pkg::ST_XFER && d.state == awce_pkg::ST_PROG
      |=> q.bsy && !q.drq)
      else $error("last sector did not set busy");
   a_multi_abort: assert property (
      cmdAcc && (apbReq.pwdata[7:0] == `AWCE_OP_MULTI) && !q.blkEn
      |-> ##2 q.err == `AWCE_ER_ABRT && q.errFlag && !q.drq)
      else $error("block write not aborted");
   a_err_address: assert property (
      q.state == awce_pkg::ST_PROG && mediaDone && mediaErr
      |=> $stable(q.secCnt) && $stable(q.secNum) && $stable(q.cylLo))
      else $error("error moved address or count");
   a_long_single: assert property (
      q.state == awce_pkg::ST_PROG && isLong |-> q.remain == 9'h001)
      else $error("long write spans more than one sector");
   a_erased_byte: assert property (
      q.state == awce_pkg::ST_OUT |->
      infoByte(`AWCE_TB_ERASED, q.info) == {8{q.info.erased}})
      else $error("erased flag byte wrong");

   c_multi_done: cover property (
      isMulti && q.state == awce_pkg::ST_PROG ##1 q.state == awce_pkg::ST_IDLE);
   c_dma_done: cover property (
      isDma && $rose(q.irq));
   c_xlate_out: cover property (
      q.state == awce_pkg::ST_OUT ##1 q.state == awce_pkg::ST_IDLE);
   c_long_ecc: cover property (
      q.state == awce_pkg::ST_ECC ##1 q.state == awce_pkg::ST_PROG);
endmodule : awce_engine

// ===== design/awce_regs.svh
`ifndef AWCE_REGS_SVH
`define AWCE_REGS_SVH
// How it works
// - 87H returns a 512-byte sector information block
// - cylinder MSB first, then head, then sector
// - bytes 04H-06H hold LBA, MSB first
// - byte 13H is FFh if erased, else 00h
// - bytes 18H-1AH hold wear count, zero unsupported
// - E8H loads 512 bytes into sector buffer
// - DMA transfers are qualified by the request line
// - DMA write raises one interrupt, at the end
// - DMA write keeps busy or data-request set
// - 32H/33H write one 516-byte sector only
// - long write: 512 data bytes, then 4 bytes
// - host check bytes are dropped, own check used
// - C5H sets busy within 400 ns of accept
// - block size at most one sector, advertised
// - data request at each sector start, not only at each block start
// - interrupt at each block start, not per sector
// - count in sectors; last block holds the remainder
// - block write aborts when block mode is off
// - error ends command at failing sector
// - error leaves failing address and residual count
// - CDH behaves exactly as C5H
// - sector write: busy, then data request, no interrupt
// - after last sector: busy until done, then interrupt
// - block mode off after reset until configured

// apb byte offsets
`define AWCE_OFF_DATA    8'h00
`define AWCE_OFF_SECCNT  8'h04
`define AWCE_OFF_SECNUM  8'h08
`define AWCE_OFF_CYLLO   8'h0c
`define AWCE_OFF_CYLHI   8'h10
`define AWCE_OFF_DEVHEAD 8'h14
`define AWCE_OFF_CMDSTAT 8'h18
`define AWCE_OFF_ERROR   8'h1c
`define AWCE_OFF_MULTI   8'h20
// opcodes
`define AWCE_OP_XLATE    8'h87
`define AWCE_OP_WRBUF    8'he8
`define AWCE_OP_WRDMA    8'hca
`define AWCE_OP_LONG0    8'h32
`define AWCE_OP_LONG1    8'h33
`define AWCE_OP_MULTI    8'hc5
`define AWCE_OP_MULTINE  8'hcd
`define AWCE_OP_SETMULT  8'hc6
// status and error bits
`define AWCE_ST_BSY      7
`define AWCE_ST_RDY      6
`define AWCE_ST_DSC      4
`define AWCE_ST_DRQ      3
`define AWCE_ST_ERR      0
`define AWCE_ER_IDNF     8'h10
`define AWCE_ER_ABRT     8'h04
// information block byte positions
`define AWCE_TB_CYLMSB   9'h000
`define AWCE_TB_CYLLSB   9'h001
`define AWCE_TB_HEAD     9'h002
`define AWCE_TB_SECT     9'h003
`define AWCE_TB_LBA0     9'h004
`define AWCE_TB_LBA1     9'h005
`define AWCE_TB_LBA2     9'h006
`define AWCE_TB_ERASED   9'h013
`define AWCE_TB_HOT0     9'h018
`define AWCE_TB_HOT1     9'h019
`define AWCE_TB_HOT2     9'h01a
// sizes and timing
`define AWCE_LAST_WORD   8'hff
`define AWCE_LAST_ECC    2'h3
`define AWCE_FULL_COUNT  9'h100
`define AWCE_BSY_MAX_NS  400
`define AWCE_CLK_NS      100
`endif

// ===== design/awce_pkg.sv
package awce_pkg;
   // command sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_XFER, ST_ECC, ST_PROG, ST_OUT
   } awce_state_t;
   // apb request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } awce_apb_t;
   // sector facts supplied by the media manager
   typedef struct packed {
      logic [15:0] cyl;
      logic [7:0]  head;
      logic [7:0]  sect;
      logic [23:0] lba;
      logic        erased;
      logic [23:0] hot;
   } awce_info_t;
   // sector program request to the media manager
   typedef struct packed {
      logic        req;
      logic [27:0] lba;
   } awce_media_t;
endpackage : awce_pkg

// ===== sim/awce_media_model.sv
`timescale 1ns/1ps
// media manager stand-in: answers each program request after a delay
module awce_media_model (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire awce_pkg::awce_media_t mediaOut,
   input  wire logic                  slow,
   input  wire logic [27:0]           failLba,
   output logic                       mediaDone,
   output logic                       mediaErr
);
   logic [3:0]  waitCnt; // cycles left until done
   logic [27:0] curLba;  // sector being programmed
   // one done pulse per request, never in the request cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         waitCnt   <= 4'h0;
         curLba    <= '0;
         mediaDone <= 1'b0;
         mediaErr  <= 1'b0;
      end else begin
         mediaDone <= 1'b0;
         mediaErr  <= ~mediaErr; // meaningless outside a done pulse
         if (mediaOut.req) begin
            waitCnt <= slow ? 4'h9 : 4'h1;
            curLba  <= mediaOut.lba;
         end else if (waitCnt == 4'h1) begin
            waitCnt   <= 4'h0;
            mediaDone <= 1'b1;
            mediaErr  <= (curLba == failLba);
         end else if (waitCnt != 4'h0) begin
            waitCnt <= waitCnt - 4'h1;
         end
      end
   end
endmodule : awce_media_model

// ===== sim/tb.sv
`timescale 1ns/1ps
`include "awce_regs.svh"
module tb;
   logic                  sys_clk, rst, ce, irq, dmarq, dmaStb;
   logic                  pready, pslverr, mediaDone, mediaErr, slow, errSeen;
   awce_pkg::awce_apb_t   apbReq;
   awce_pkg::awce_info_t  sectInfo;
   awce_pkg::awce_media_t mediaOut;
   logic [31:0]           prdata, rd;
   logic [15:0]           dmaData, mediaRdData;
   logic [7:0]            mediaRdAddr;
   logic [7:0]            blk [0:511]; // expected information block
   logic [27:0]           failLba;
   int                    miscompares, num_checks, reqCnt, r0;
   logic [7:0]            rows [5][3]; // count, opcode, error code
   awce_engine #(.MAX_BLOCK(1)) u_dut (.sys_clk(sys_clk), .rst(rst),
      .ce(ce), .apbReq(apbReq), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .dmarq(dmarq), .dmaStb(dmaStb),
      .dmaData(dmaData), .sectInfo(sectInfo), .mediaOut(mediaOut),
      .mediaDone(mediaDone), .mediaErr(mediaErr),
      .mediaRdAddr(mediaRdAddr), .mediaRdData(mediaRdData));
   awce_media_model u_media (.sys_clk(sys_clk), .rst(rst),
      .mediaOut(mediaOut), .slow(slow), .failLba(failLba),
      .mediaDone(mediaDone), .mediaErr(mediaErr));
   // free-running clock, 100 ns
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // count sector program requests
   always @(posedge sys_clk) begin
      if (mediaOut.req === 1'b1) reqCnt++;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one apb transfer, then one idle edge
   task automatic apb(input logic w, input logic [7:0] a, input int d);
      int n;
      n = 0;
      apbReq <= '{1'b1, 1'b0, w, a, d};
      @(posedge sys_clk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      errSeen = pslverr;
      if (n >= 50) begin
         miscompares++;
         tally_and_finish();
      end
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic wait_irq();
      int n;
      for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge sys_clk);
      if (n >= 3000) begin
         chk("irq wait", 0, 1);
         tally_and_finish();
      end
   endtask : wait_irq
   task automatic wait_drq();
      int n;
      for (n = 0; n < 50; n++) begin
         apb(0, `AWCE_OFF_CMDSTAT, 0);
         if (rd[3] === 1'b1) break;
      end
      if (n >= 50) begin
         chk("drq wait", 0, 1);
         tally_and_finish();
      end
   endtask : wait_drq
   task automatic put256(input int base);
      for (int i = 0; i < 256; i++) apb(1, `AWCE_OFF_DATA, base + i);
   endtask : put256
   // main sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      apbReq = '0;
      dmaStb = 1'b0;
      dmaData = '0;
      mediaRdAddr = '0;
      slow = 1'b0;
      failLba = '1;
      sectInfo = '{16'h1234, 8'h05, 8'h2a, 24'h0abcde, 1'b1, 24'h010203};
      rows = '{'{1, 8'hc5, 4}, '{1, 8'hcd, 4}, '{0, 0, 4}, '{2, 8'hc6, 4},
               '{0, 8'hc6, 0}};
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      apb(0, `AWCE_OFF_CMDSTAT, 0);
      chk("idle status", rd[7:0], 8'h50);
      apb(0, `AWCE_OFF_MULTI, 0);
      chk("block limit", rd[15:0], 16'h0100);
      apb(0, 8'h24, 0);
      chk("unmapped err", errSeen, 1'b1);
      chk("unmapped data", rd, 32'h0);
      $display("reset test done");
      // aborted commands, then C6H with count 0 (no error), block mode off
      foreach (rows[i]) begin
         apb(1, `AWCE_OFF_SECCNT, rows[i][0]);
         apb(1, `AWCE_OFF_CMDSTAT, rows[i][1]);
         wait_irq();
         apb(0, `AWCE_OFF_ERROR, 0);
         chk("abort code", rd[7:0], rows[i][2]);
      end
      $display("abort test done");
      apb(1, `AWCE_OFF_CMDSTAT, `AWCE_OP_WRBUF);
      wait_drq();
      chk("no early irq", irq, 1'b0);
      put256(32'ha500);
      wait_irq();
      mediaRdAddr <= 8'h05;
      repeat (2) @(posedge sys_clk);
      chk("buffer word", mediaRdData, 16'ha505);
      chk("buffer programs", reqCnt, 0);
      $display("buffer test done");
      blk = '{default: 8'h00};
      {blk[0], blk[1], blk[2], blk[3]} = 32'h1234052a;
      {blk[4], blk[5], blk[6], blk[19]} = 32'h0abcdeff;
      {blk[24], blk[25], blk[26]} = 24'h010203;
      apb(1, `AWCE_OFF_CMDSTAT, `AWCE_OP_XLATE);
      wait_irq();
      wait_drq();
      for (int i = 0; i < 256; i++) begin
         apb(0, `AWCE_OFF_DATA, 0);
         chk("info", rd[15:0], {blk[2*i+1], blk[2*i]});
      end
      $display("info test done");
      apb(1, `AWCE_OFF_SECCNT, 1);
      apb(1, `AWCE_OFF_CMDSTAT, `AWCE_OP_SETMULT);
      wait_irq();
      slow <= 1'b1;
      failLba <= 28'h11;
      apb(1, `AWCE_OFF_SECCNT, 2);
      apb(1, `AWCE_OFF_SECNUM, 8'h10);
      apb(1, `AWCE_OFF_CYLLO, 0);
      apb(1, `AWCE_OFF_CYLHI, 0);
      apb(1, `AWCE_OFF_DEVHEAD, 8'he0);
      r0 = reqCnt;
      apb(1, `AWCE_OFF_CMDSTAT, `AWCE_OP_MULTI);
      for (int s = 0; s < 2; s++) begin
         wait_irq();
         apb(0, `AWCE_OFF_CMDSTAT, 0);
         chk("block start", rd[7:0], 8'h58);
         put256(s);
      end
      wait_irq();
      apb(0, `AWCE_OFF_ERROR, 0);
      chk("media error", rd[7:0] + reqCnt - r0, 8'h12);
      apb(0, `AWCE_OFF_SECCNT, 0);
      chk("residual", rd[7:0], 8'h01);
      apb(0, `AWCE_OFF_SECNUM, 0);
      chk("fail sector", rd[7:0], 8'h11);
      $display("block test done");
      slow <= 1'b0;
      failLba <= '1;
      apb(1, `AWCE_OFF_SECCNT, 1);
      apb(1, `AWCE_OFF_CMDSTAT, `AWCE_OP_WRDMA);
      for (int n = 0; n < 20 && dmarq !== 1'b1; n++) @(posedge sys_clk);
      chk("dma request", dmarq, 1'b1);
      if (dmarq !== 1'b1) tally_and_finish();
      for (int i = 0; i < 256; i++) begin
         dmaData <= i[15:0];
         dmaStb <= 1'b1;
         @(posedge sys_clk);
      end
      dmaStb <= 1'b0;
      chk("dma irq early", irq, 1'b0);
      wait_irq();
      apb(0, `AWCE_OFF_CMDSTAT, 0);
      chk("dma end", rd[7:0], 8'h50);
      chk("dma request end", dmarq, 1'b0);
      $display("dma test done");
      // long writes ignore the count and program one sector
      for (int k = 0; k < 2; k++) begin
         r0 = reqCnt;
         apb(1, `AWCE_OFF_SECCNT, 5);
         apb(1, `AWCE_OFF_CMDSTAT, 8'h32 + k);
         wait_drq();
         put256(0);
         repeat (4) apb(1, `AWCE_OFF_DATA, 8'h3c);
         wait_irq();
         chk("long programs", reqCnt - r0, 1);
      end
      $display("long test done");
      // legacy alias runs one full block write
      r0 = reqCnt;
      apb(1, `AWCE_OFF_SECCNT, 1);
      apb(1, `AWCE_OFF_CMDSTAT, `AWCE_OP_MULTINE);
      wait_irq();
      apb(0, `AWCE_OFF_CMDSTAT, 0);
      chk("alias start", rd[7:0], 8'h58);
      put256(7);
      wait_irq();
      apb(0, `AWCE_OFF_CMDSTAT, 0);
      chk("alias end", rd[7:0], 8'h50);
      chk("alias programs", reqCnt - r0, 1);
      $display("alias test done");
      // hardware reset in mid-run turns block mode off again
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      apb(0, `AWCE_OFF_MULTI, 0);
      chk("block off", rd[15:0], 16'h0100);
      apb(0, `AWCE_OFF_CMDSTAT, 0);
      chk("reset status", rd[7:0], 8'h50);
      $display("second reset test done");
      tally_and_finish();
   end
endmodule : tb
